// *** verilog/alarm_pkg.sv ***
//==============================================================================
// Purpose: Constants and carriers for the process alarm evaluator.
// Assumes: Signed 16-bit process, set point and manipulated values.
//==============================================================================
package alarm_pkg;
    localparam int NUM_CH = 3;
    localparam int NUM_AUX = 3;
    localparam int VAL_W = 16;
    localparam int DLY_W = 10;
    // Type codes.
    localparam logic [4:0] TYPE_OFF = 5'h00;
    localparam logic [4:0] TYPE_BAND_OUT = 5'h01;
    localparam logic [4:0] TYPE_UPPER = 5'h02;
    localparam logic [4:0] TYPE_LOWER = 5'h03;
    localparam logic [4:0] TYPE_BAND_IN = 5'h04;
    localparam logic [4:0] TYPE_BAND_OUT_SB = 5'h05;
    localparam logic [4:0] TYPE_UPPER_SB = 5'h06;
    localparam logic [4:0] TYPE_LOWER_SB = 5'h07;
    localparam logic [4:0] TYPE_ABS_HI = 5'h08;
    localparam logic [4:0] TYPE_ABS_LO = 5'h09;
    localparam logic [4:0] TYPE_ABS_HI_SB = 5'h0A;
    localparam logic [4:0] TYPE_ABS_LO_SB = 5'h0B;
    localparam logic [4:0] TYPE_LOOP_BREAK = 5'h0C;
    localparam logic [4:0] TYPE_RATE = 5'h0D;
    localparam logic [4:0] TYPE_SP_HI = 5'h0E;
    localparam logic [4:0] TYPE_SP_LO = 5'h0F;
    localparam logic [4:0] TYPE_MV_HI = 5'h10;
    localparam logic [4:0] TYPE_MV_LO = 5'h11;
    localparam logic [4:0] TYPE_RESET = TYPE_UPPER;
    // Delay limit in seconds, and the sample ticks that make one second.
    localparam logic [9:0] DELAY_MAX = 10'h3E7;
    localparam int TICKS_PER_SEC = 10;
    localparam logic [3:0] SEC_LAST = 4'(TICKS_PER_SEC - 1);
    // Output assignment codes: 1..3 pick alarm channels 1..3.
    localparam logic [2:0] ASSIGN_NONE = 3'h0;
    localparam logic [2:0] ASSIGN_ALARM1 = 3'h1;
    localparam logic [2:0] ASSIGN_ALARM2 = 3'h2;
    localparam logic [2:0] ASSIGN_ALARM3 = 3'h3;
    localparam logic [2:0] ASSIGN_HEATER = 3'h4;
    localparam logic [2:0] ASSIGN_RESET0 = ASSIGN_HEATER;
    localparam logic [2:0] ASSIGN_RESET1 = ASSIGN_ALARM2;
    localparam logic [2:0] ASSIGN_RESET2 = ASSIGN_ALARM3;
    localparam logic [15:0] THRESH_RESET = 16'h0000;
    localparam logic [9:0] DELAY_RESET = 10'h000;

    typedef struct packed {
        logic [4:0] kind;
        logic signed [VAL_W-1:0] hi;
        logic signed [VAL_W-1:0] lo;
        logic [DLY_W-1:0] on_dly;
        logic [DLY_W-1:0] off_dly;
    } alarm_cfg_s;

    typedef struct packed {
        logic signed [VAL_W-1:0] pv;
        logic signed [VAL_W-1:0] sp;
        logic signed [VAL_W-1:0] mv_heat;
        logic signed [VAL_W-1:0] mv_cool;
    } loop_vals_s;
endpackage

// *** verilog/process_alarm_evaluator.sv ***
//==============================================================================
// Purpose: Evaluates alarm channels per sample tick and drives auxiliary outputs.
// Assumes: All inputs come from logic on CLK_SYS; SAMPLE_TICK is a one-cycle pulse.
// Notes: Rejected configuration writes leave the stored setting unchanged.
//==============================================================================
`timescale 1ns/1ps
module process_alarm_evaluator (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic SAMPLE_TICK,
    input wire alarm_pkg::loop_vals_s LOOP_VALS,
    input wire logic HEAT_COOL_MODE,
    input wire logic HEATER_VARIANT,
    input wire logic HEATER_FAULT,
    input wire logic LOOP_BREAK_IN,
    input wire logic RATE_ALARM_IN,
    input wire logic STANDBY_RESTART,
    input wire logic CFG_WR,
    input wire logic [1:0] CFG_SEL,
    input wire alarm_pkg::alarm_cfg_s CFG_DATA,
    input wire logic ASSIGN_WR,
    input wire logic [1:0] ASSIGN_SEL,
    input wire logic [2:0] ASSIGN_CODE,
    output logic [alarm_pkg::NUM_CH-1:0] ALARM_OUT,
    output logic [alarm_pkg::NUM_AUX-1:0] AUX_OUT,
    output logic [alarm_pkg::NUM_CH-1:0] STANDBY_ACTIVE,
    output logic CFG_ERR,
    output logic [4:0] CH1_TYPE
);
    import alarm_pkg::*;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    //==========================================================================
    // Configuration storage.
    //==========================================================================
    alarm_cfg_s cfg_ff [NUM_CH];
    logic [2:0] assign_ff [NUM_AUX];
    logic cfg_err_ff;
    logic ch1_selected;
    logic ch1_heater;
    logic cfg_bad;

    // Channel 1 acts as a normal alarm once some output picks it.
    always_comb begin
        ch1_selected = 1'b0;
        for (int a = 0; a < NUM_AUX; a++) begin
            if (assign_ff[a] == ASSIGN_ALARM1) begin
                ch1_selected = 1'b1;
            end
        end
        ch1_heater = HEATER_VARIANT && !ch1_selected;
    end

    // A write is refused for unknown codes, loop break off channel 1, a hidden type,
    // an out of range delay or a channel that does not exist.
    always_comb begin
        cfg_bad = (CFG_DATA.kind > TYPE_MV_LO)
            || (CFG_DATA.kind == TYPE_LOOP_BREAK && CFG_SEL != 2'h0)
            || (CFG_SEL == 2'h0 && ch1_heater)
            || (CFG_DATA.on_dly > DELAY_MAX) || (CFG_DATA.off_dly > DELAY_MAX)
            || (32'(CFG_SEL) >= NUM_CH);
    end

    // Store accepted channel settings; reset gives upper deviation type.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cfg_ff[c] <= '{TYPE_RESET, THRESH_RESET, THRESH_RESET, DELAY_RESET,
                    DELAY_RESET};
            end
        end else if (CFG_WR && !cfg_bad) begin
            cfg_ff[CFG_SEL] <= CFG_DATA;
        end
    end

    // Flag a refused write for one cycle.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cfg_err_ff <= 1'b0;
        end else begin
            cfg_err_ff <= CFG_WR && cfg_bad;
        end
    end

    // Store output assignments.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            assign_ff[0] <= ASSIGN_RESET0;
            assign_ff[1] <= ASSIGN_RESET1;
            assign_ff[2] <= ASSIGN_RESET2;
        end else if (ASSIGN_WR && 32'(ASSIGN_SEL) < NUM_AUX && ASSIGN_CODE <= ASSIGN_HEATER) begin
            assign_ff[ASSIGN_SEL] <= ASSIGN_CODE;
        end
    end

    assign CFG_ERR = cfg_err_ff;
    assign CH1_TYPE = cfg_ff[0].kind;

    //==========================================================================
    // Seconds prescaler on the sample tick.
    //==========================================================================
    logic [3:0] sec_cnt_ff;
    logic sec_pulse;

    // Count ticks; the last tick of each second carries the second pulse.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sec_cnt_ff <= 4'h0;
        end else if (SAMPLE_TICK) begin
            sec_cnt_ff <= (sec_cnt_ff == SEC_LAST) ? 4'h0 : sec_cnt_ff + 4'h1;
        end
    end
    assign sec_pulse = SAMPLE_TICK && (sec_cnt_ff == SEC_LAST);

    //==========================================================================
    // Per-channel evaluation, standby and delays.
    //==========================================================================
    logic [NUM_CH-1:0] raw;
    logic [NUM_CH-1:0] cond;
    logic [NUM_CH-1:0] out_ff;
    logic [NUM_CH-1:0] sb_ff;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic signed [VAL_W+1:0] pv;
        logic signed [VAL_W+1:0] sp;
        logic signed [VAL_W+1:0] hi;
        logic signed [VAL_W+1:0] lo;
        logic signed [VAL_W+1:0] mv_up;
        logic signed [VAL_W+1:0] mv_dn;
        logic band_out;
        logic overlap;
        logic uses_sb;
        logic [DLY_W-1:0] cnt_ff;
        logic [4:0] kind;

        assign kind = cfg_ff[g].kind;
        assign pv = (VAL_W+2)'(LOOP_VALS.pv);
        assign sp = (VAL_W+2)'(LOOP_VALS.sp);
        assign hi = (VAL_W+2)'(cfg_ff[g].hi);
        assign lo = (VAL_W+2)'(cfg_ff[g].lo);
        assign mv_up = (VAL_W+2)'(LOOP_VALS.mv_heat);
        assign mv_dn = HEAT_COOL_MODE ? (VAL_W+2)'(LOOP_VALS.mv_cool)
            : (VAL_W+2)'(LOOP_VALS.mv_heat);
        assign band_out = (pv >= sp + hi) || (pv <= sp - lo);
        assign overlap = (hi + lo) <= (VAL_W+2)'(0);
        assign uses_sb = kind == TYPE_BAND_OUT_SB || kind == TYPE_UPPER_SB
            || kind == TYPE_LOWER_SB || kind == TYPE_ABS_HI_SB || kind == TYPE_ABS_LO_SB;

        // Compare the selected value against the threshold for this type.
        always_comb begin
            case (kind)
                TYPE_BAND_OUT: cond[g] = band_out;
                TYPE_UPPER, TYPE_UPPER_SB: cond[g] = pv >= sp + hi;
                TYPE_LOWER, TYPE_LOWER_SB: cond[g] = pv <= sp - hi;
                TYPE_BAND_IN: cond[g] = !band_out;
                TYPE_BAND_OUT_SB: cond[g] = band_out && !overlap;
                TYPE_ABS_HI, TYPE_ABS_HI_SB: cond[g] = pv > hi;
                TYPE_ABS_LO, TYPE_ABS_LO_SB: cond[g] = pv < hi;
                TYPE_LOOP_BREAK: cond[g] = (g == 0) && LOOP_BREAK_IN;
                TYPE_RATE: cond[g] = RATE_ALARM_IN;
                TYPE_SP_HI: cond[g] = sp > hi;
                TYPE_SP_LO: cond[g] = sp < hi;
                TYPE_MV_HI: cond[g] = mv_up > hi;
                TYPE_MV_LO: cond[g] = mv_dn < hi;
                default: cond[g] = 1'b0;
            endcase
            if (g == 0 && ch1_heater) begin
                raw[g] = HEATER_FAULT;
            end else begin
                raw[g] = cond[g] && !(uses_sb && sb_ff[g]);
            end
        end

        // Standby holds off until the condition is first seen clear on a tick.
        always_ff @(posedge CLK_SYS) begin
            if (!RST_N) begin
                sb_ff[g] <= 1'b1;
            end else if (STANDBY_RESTART) begin
                sb_ff[g] <= 1'b1;
            end else if (SAMPLE_TICK && !cond[g]) begin
                sb_ff[g] <= 1'b0;
            end
        end

        // Apply the assertion or release delay, counted in whole seconds.
        always_ff @(posedge CLK_SYS) begin
            if (!RST_N) begin
                out_ff[g] <= 1'b0;
                cnt_ff <= DELAY_RESET;
            end else if (SAMPLE_TICK) begin
                if (raw[g] == out_ff[g]) begin
                    cnt_ff <= DELAY_RESET;
                end else if (cnt_ff >= (raw[g] ? cfg_ff[g].on_dly : cfg_ff[g].off_dly)) begin
                    out_ff[g] <= raw[g];
                    cnt_ff <= DELAY_RESET;
                end else if (sec_pulse) begin
                    cnt_ff <= cnt_ff + 10'h001;
                end
            end
        end

        a_out_on_tick: assert property (!SAMPLE_TICK |=> $stable(out_ff[g]))
            else $error("alarm output moved without a sample tick");
        a_zero_on_delay: assert property (SAMPLE_TICK && raw[g] && !out_ff[g]
            && cfg_ff[g].on_dly == 10'h000 |=> out_ff[g])
            else $error("zero assertion delay did not act at the tick");
        a_type_off_quiet: assert property (kind == TYPE_OFF && !(g == 0 && ch1_heater)
            |-> !raw[g])
            else $error("disabled alarm raised a result");
        a_upper_dev: assert property (kind == TYPE_UPPER && !(g == 0 && ch1_heater)
            |-> raw[g] == (pv >= sp + hi))
            else $error("upper deviation result wrong");
        a_band_overlap: assert property (kind == TYPE_BAND_OUT_SB && overlap |-> !raw[g])
            else $error("overlapping bands raised the standby band alarm");
        a_standby_hold: assert property (uses_sb && sb_ff[g] && !(g == 0 && ch1_heater)
            |-> !raw[g])
            else $error("standby did not suppress the alarm");
        a_abs_lower: assert property (kind == TYPE_ABS_LO && !(g == 0 && ch1_heater)
            |-> raw[g] == (pv < hi))
            else $error("absolute lower result wrong");
    end

    assign ALARM_OUT = out_ff;
    assign STANDBY_ACTIVE = sb_ff;

    //==========================================================================
    // Auxiliary output routing.
    //==========================================================================
    logic [NUM_AUX-1:0] aux_ff;

    // Each auxiliary output follows its assigned source one cycle later.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            aux_ff <= '0;
        end else begin
            for (int a = 0; a < NUM_AUX; a++) begin
                case (assign_ff[a])
                    ASSIGN_ALARM1: aux_ff[a] <= out_ff[0];
                    ASSIGN_ALARM2: aux_ff[a] <= out_ff[1];
                    ASSIGN_ALARM3: aux_ff[a] <= out_ff[2];
                    ASSIGN_HEATER: aux_ff[a] <= HEATER_FAULT;
                    default: aux_ff[a] <= 1'b0;
                endcase
            end
        end
    end
    assign AUX_OUT = aux_ff;

    // A missing channel index has no storage to look at, so only the error flag counts there.
    a_lba_reject: assert property (CFG_WR && CFG_DATA.kind == TYPE_LOOP_BREAK
        && CFG_SEL != 2'h0 |=> CFG_ERR && (32'($past(CFG_SEL)) >= NUM_CH
        || cfg_ff[$past(CFG_SEL)].kind != TYPE_LOOP_BREAK))
        else $error("loop break type accepted off channel 1");
    a_aux_route: assert property (assign_ff[1] == ASSIGN_ALARM2
        |=> AUX_OUT[1] == $past(out_ff[1]))
        else $error("auxiliary output does not follow its alarm");
    a_mv_heat: assert property (HEAT_COOL_MODE && cfg_ff[1].kind == TYPE_MV_HI
        |-> raw[1] == (g_ch[1].mv_up > g_ch[1].hi))
        else $error("manipulated upper alarm not on heating output");
endmodule

// *** test/loop_model.sv ***
//==============================================================================
// Purpose: Control loop model that supplies the sample tick and the loop values.
// Assumes: One clock; values move only when a tick is raised, as a sampled loop does.
// Notes: The tick spacing in clocks is a parameter.
//==============================================================================
`timescale 1ns/1ps
module loop_model #(
    parameter int GAP = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire alarm_pkg::loop_vals_s req,
    output alarm_pkg::loop_vals_s vals,
    output logic tick
);
    import alarm_pkg::*;
    logic [7:0] cnt_ff;
    // Counts clocks and raises a one-cycle tick.
    // New values land with the tick, so they never change between ticks.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            tick <= 1'b0;
            vals <= '0;
        end else begin
            cnt_ff <= (cnt_ff == 8'(GAP - 1)) ? 8'h00 : cnt_ff + 8'h01;
            tick <= (cnt_ff == 8'(GAP - 1));
            if (cnt_ff == 8'(GAP - 1)) begin
                vals <= req;
            end
        end
    end
endmodule

// *** test/process_alarm_evaluator_tb.sv ***
//==============================================================================
// Purpose: Self-checking bench for the process alarm evaluator.
// Assumes: The loop model ticks every 4 clocks; one second is 10 ticks.
// Notes: The type sweep uses channel 2, seen directly and through aux output 1.
//==============================================================================
`timescale 1ns/1ps
module process_alarm_evaluator_tb;
    import alarm_pkg::*;
    typedef struct packed {
        logic [4:0] k;
        logic signed [15:0] pv, sp, mh, mc, hi, lo;
        logic hm, rt, x;
    } row_s;
    // Fields: type, pv, sp, mv heat, mv cool, hi, lo, heat/cool, rate, expected.
    row_s tab [23] = '{
        '{0, 100, 0, 0, 0, 0, 0, 0, 0, 0},
        '{1, 20, 0, 0, 0, 10, 10, 0, 0, 1},
        '{1, 0, 0, 0, 0, 10, 10, 0, 0, 0},
        '{2, 10, 0, 0, 0, 10, 0, 0, 0, 1},
        '{2, 9, 0, 0, 0, 10, 0, 0, 0, 0},
        '{2, -5, 0, 0, 0, -5, 0, 0, 0, 1},
        '{3, -10, 0, 0, 0, 10, 0, 0, 0, 1},
        '{3, -9, 0, 0, 0, 10, 0, 0, 0, 0},
        '{4, 0, 0, 0, 0, 10, 10, 0, 0, 1},
        '{4, 20, 0, 0, 0, 10, 10, 0, 0, 0},
        '{8, 10, 0, 0, 0, 10, 0, 0, 0, 0},
        '{8, 11, 0, 0, 0, 10, 0, 0, 0, 1},
        '{9, 10, 0, 0, 0, 10, 0, 0, 0, 0},
        '{9, 9, 0, 0, 0, 10, 0, 0, 0, 1},
        '{13, 0, 0, 0, 0, 0, 0, 0, 1, 1},
        '{13, 0, 0, 0, 0, 0, 0, 0, 0, 0},
        '{14, 0, 11, 0, 0, 10, 0, 0, 0, 1},
        '{15, 0, 10, 0, 0, 10, 0, 0, 0, 0},
        '{16, 0, 0, 11, 0, 10, 0, 0, 0, 1},
        '{16, 0, 0, 9, 20, 10, 0, 1, 0, 0},
        '{17, 0, 0, 9, 20, 10, 0, 1, 0, 0},
        '{17, 0, 0, 9, 20, 10, 0, 0, 0, 1},
        '{5, 100, 0, 0, 0, 5, -5, 0, 0, 0}
    };
    logic [4:0] sbk [5] = '{5'h05, 5'h06, 5'h07, 5'h0A, 5'h0B};
    logic signed [15:0] pvt [5] = '{16'sd20, 16'sd20, -16'sd20, 16'sd20, 16'sd0};
    logic signed [15:0] pvf [5] = '{16'sd0, 16'sd0, 16'sd0, 16'sd0, 16'sd20};
    logic clk_sys = 1'b0, rst_n = 1'b0, sample_tick, cfg_err;
    logic hc = 1'b0, hv = 1'b0, hf = 1'b0, lb = 1'b0, rt = 1'b0, sr = 1'b0;
    logic cfg_wr = 1'b0, as_wr = 1'b0;
    logic [1:0] cfg_sel = 2'h0, as_sel = 2'h0;
    logic [2:0] as_code = 3'h0, alarm_out, aux_out, sb_act;
    logic [4:0] ch1_type;
    loop_vals_s req = '0, vals;
    alarm_cfg_s cfg = '0;
    int errors = 0, check_count = 0;
    //==========================================================================
    // Clock, model and design
    //==========================================================================
    always #10 clk_sys = ~clk_sys;
    loop_model #(.GAP(4)) model_u (.clk(clk_sys), .rst_n(rst_n), .req(req), .vals(vals),
        .tick(sample_tick));
    process_alarm_evaluator dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .SAMPLE_TICK(sample_tick),
        .LOOP_VALS(vals), .HEAT_COOL_MODE(hc), .HEATER_VARIANT(hv), .HEATER_FAULT(hf),
        .LOOP_BREAK_IN(lb), .RATE_ALARM_IN(rt), .STANDBY_RESTART(sr), .CFG_WR(cfg_wr),
        .CFG_SEL(cfg_sel), .CFG_DATA(cfg), .ASSIGN_WR(as_wr), .ASSIGN_SEL(as_sel),
        .ASSIGN_CODE(as_code), .ALARM_OUT(alarm_out), .AUX_OUT(aux_out),
        .STANDBY_ACTIVE(sb_act), .CFG_ERR(cfg_err), .CH1_TYPE(ch1_type));
    //==========================================================================
    // Shared tasks
    //==========================================================================
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Waits for n ticks, then two clocks so the alarm and aux outputs settle.
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys iff sample_tick);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // One config write; the error flag must pulse for exactly one cycle when refused.
    task automatic wcfg(input logic [1:0] sel, input logic [4:0] k, input logic [15:0] h,
            input logic [15:0] l, input logic [9:0] ond, input logic [9:0] offd,
            input logic e);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_sel <= sel;
        cfg <= '{k, h, l, ond, offd};
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        #1;
        chk("cfg_err", 16'(e), 16'(cfg_err));
        @(posedge clk_sys);
        #1;
        chk("cfg_err drop", 16'h0000, 16'(cfg_err));
    endtask
    task automatic wasg(input logic [1:0] sel, input logic [2:0] code);
        @(posedge clk_sys);
        as_wr <= 1'b1;
        as_sel <= sel;
        as_code <= code;
        @(posedge clk_sys);
        as_wr <= 1'b0;
    endtask
    task automatic setv(input logic [15:0] pv, input logic [15:0] sp, input logic [15:0] mh,
            input logic [15:0] mc, input logic hm, input logic r);
        @(posedge clk_sys);
        req <= '{pv, sp, mh, mc};
        hc <= hm;
        rt <= r;
    endtask
    task automatic setp(input logic [15:0] pv);
        setv(pv, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
    endtask
    //==========================================================================
    // Scenarios
    //==========================================================================
    task automatic t_reset();
        chk("alarm_out", 16'h0000, 16'(alarm_out));
        chk("aux_out", 16'h0000, 16'(aux_out));
        chk("standby", 16'h0007, 16'(sb_act));
        chk("ch1_type", 16'h0002, 16'(ch1_type));
        $display("test reset done");
    endtask
    // Every type except 6, 7, 10, 11 and loop break, with boundary values, through the table above.
    task automatic t_types();
        foreach (tab[i]) begin
            wcfg(2'h1, tab[i].k, tab[i].hi, tab[i].lo, 10'h000, 10'h000, 1'b0);
            setv(tab[i].pv, tab[i].sp, tab[i].mh, tab[i].mc, tab[i].hm, tab[i].rt);
            settle(3);
            chk($sformatf("alarm2 row %0d", i), 16'(tab[i].x), 16'(alarm_out[1]));
            chk($sformatf("aux1 row %0d", i), 16'(tab[i].x), 16'(aux_out[1]));
        end
        $display("test types done");
    endtask
    // Standby holds the alarm off until the condition has once been false.
    task automatic t_standby();
        for (int i = 0; i < 5; i++) begin
            wcfg(2'h1, sbk[i], 16'sd10, 16'sd10, 10'h000, 10'h000, 1'b0);
            setp(pvt[i]);
            settle(2);
            @(posedge clk_sys);
            sr <= 1'b1;
            @(posedge clk_sys);
            sr <= 1'b0;
            settle(3);
            chk("standby hold", 16'h0000, 16'(alarm_out[1]));
            chk("standby flag", 16'h0001, 16'(sb_act[1]));
            setp(pvf[i]);
            settle(3);
            chk("standby clear", 16'h0000, 16'(sb_act[1]));
            setp(pvt[i]);
            settle(3);
            chk("standby alarm", 16'h0001, 16'(alarm_out[1]));
        end
        $display("test standby done");
    endtask
    task automatic t_refuse();
        wcfg(2'h1, TYPE_LOOP_BREAK, 16'h0000, 16'h0000, 10'h000, 10'h000, 1'b1);
        wcfg(2'h1, 5'h12, 16'h0000, 16'h0000, 10'h000, 10'h000, 1'b1);
        wcfg(2'h1, TYPE_UPPER, 16'h0000, 16'h0000, 10'h3E8, 10'h000, 1'b1);
        wcfg(2'h1, TYPE_UPPER, 16'h0000, 16'h0000, 10'h000, 10'h3E8, 1'b1);
        wcfg(2'h3, TYPE_UPPER, 16'h0000, 16'h0000, 10'h000, 10'h000, 1'b1);
        wcfg(2'h1, TYPE_MV_LO, 16'h0000, 16'h0000, 10'h3E7, 10'h3E7, 1'b0);
        $display("test refuse done");
    endtask
    // Assertion delay of 1 s and release delay of 2 s, counted in ticks.
    task automatic t_delay();
        int n;
        setp(-16'sd1);
        settle(3);
        wcfg(2'h2, TYPE_ABS_HI, 16'h0000, 16'h0000, 10'h001, 10'h002, 1'b0);
        for (int p = 0; p < 2; p++) begin
            setp(p == 0 ? 16'sd5 : -16'sd5);
            n = 0;
            while (alarm_out[2] !== (p == 0) && n < 26) begin
                @(posedge clk_sys iff sample_tick);
                @(posedge clk_sys);
                #1;
                n++;
            end
            chk("delay span ok", 16'h0001,
                16'(p == 0 ? (n >= 2 && n <= 12) : (n >= 12 && n <= 22)));
            @(posedge clk_sys);
            #1;
            chk("aux2 follows", 16'(p == 0), 16'(aux_out[2]));
        end
        $display("test delay done");
    endtask
    // Channel 1 carries the heater fault until an aux output selects it.
    task automatic t_heater();
        @(posedge clk_sys);
        hv <= 1'b1;
        hf <= 1'b1;
        settle(3);
        chk("heater alarm1", 16'h0001, 16'(alarm_out[0]));
        chk("heater aux0", 16'h0001, 16'(aux_out[0]));
        wcfg(2'h0, TYPE_ABS_HI, 16'h0000, 16'h0000, 10'h000, 10'h000, 1'b1);
        chk("ch1_type kept", 16'h0002, 16'(ch1_type));
        wasg(2'h0, ASSIGN_ALARM1);
        wasg(2'h2, ASSIGN_ALARM1);
        wcfg(2'h0, TYPE_LOOP_BREAK, 16'h0000, 16'h0000, 10'h000, 10'h000, 1'b0);
        chk("ch1_type new", 16'h000C, 16'(ch1_type));
        settle(2);
        chk("heater released", 16'h0000, 16'(alarm_out[0]));
        @(posedge clk_sys);
        lb <= 1'b1;
        settle(3);
        chk("loop break alarm1", 16'h0001, 16'(alarm_out[0]));
        chk("aux0 alarm1", 16'h0001, 16'(aux_out[0]));
        chk("aux2 alarm1", 16'h0001, 16'(aux_out[2]));
        @(posedge clk_sys);
        lb <= 1'b0;
        settle(3);
        chk("loop break off", 16'h0000, 16'(aux_out[0]));
        $display("test heater done");
    endtask
    //==========================================================================
    // Run control
    //==========================================================================
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_sys);
        errors++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_types();
        t_standby();
        t_refuse();
        t_delay();
        t_heater();
        report_and_stop();
    end
endmodule
